// *** hub_cfg_map.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the hub status group
// Assumes: Byte-wide register access over the two-wire bus or the back channel
// Notes: Definitions only
`ifndef HUB_CFG_MAP_SVH
`define HUB_CFG_MAP_SVH
`define OFS_GENERAL_CONFIGURATION 8'h02
`define OFS_SILICON_REVISION 8'h03
`define OFS_DEVICE_STATUS 8'h04
`define OFS_PARITY_THRESHOLD_HIGH 8'h05
`define OFS_PARITY_THRESHOLD_LOW 8'h06
`define RST_GENERAL_CONFIGURATION 8'h1E
`define RST_PARITY_THRESHOLD_HIGH 8'h01
`define RST_PARITY_THRESHOLD_LOW 8'h00
`define GC_PROXY_MASTER 5
`define GC_NOLOCK_POLICY 4
`define GC_OUTPUT_ENABLE 3
`define GC_SLEEP_SELECT 2
`define GC_PARITY_ENABLE 1
`define GC_REFCLK_OVERRIDE 0
`define GC_WRITE_MASK 8'h3F
`define ST_CKSUM 7
`define ST_INIT_DONE 6
`define ST_REFCLK_OK 4
`define ST_PASS 3
`define ST_LOCK 2
`define ST_RESERVED_LOW 2'h3
`define REFCLK_MIN_MHZ 12
`define REFCLK_MAX_MHZ 64
`define CLK_MHZ 250
`define MEAS_WINDOW_CYCLES 16'h0FA0
`define INIT_WORDS 4'h4
`endif

// *** hub_cfg_pkg.sv ***
// Purpose: Types shared by the hub status group
// Assumes: Nothing
// Notes: Constants live in hub_cfg_map.svh
package hub_cfg_pkg;
    typedef enum logic [3:0] {
        INIT_IDLE = 4'h1,
        INIT_LOAD = 4'h2,
        INIT_CHECK = 4'h4,
        INIT_DONE = 4'h8
    } init_state_t;
    typedef enum logic [1:0] {
        OUT_NORMAL = 2'h0,
        OUT_HIZ = 2'h1,
        OUT_HS0 = 2'h2,
        OUT_LP11 = 2'h3
    } out_mode_t;
endpackage

// *** hub_err_if.sv ***
// Purpose: Parity error event carrier between top and counters
// Assumes: One clock
// Notes: Plain signals with two modports
interface hub_err_if #(parameter int PORTS = 2) ();
    logic [PORTS-1:0] err;
    logic enable;
    logic [15:0] limit;
    logic [PORTS-1:0] flag;
    modport src (output err, output enable, output limit, input flag);
    modport cnt (input err, input enable, input limit, output flag);
endinterface

// *** parity_counters.sv ***
// Purpose: Per-port saturating parity error counters with threshold flags
// Assumes: Error pulses synchronous to ref_clk
// Notes: Counters clear on reset only
`include "hub_cfg_map.svh"
module parity_counters #(parameter int PORTS = 2) (
    input wire logic ref_clk,
    input wire logic rst,
    hub_err_if.cnt e
);
    logic [15:0] count [PORTS];
    logic [15:0] next_count [PORTS];
    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : gen_port
            always_comb begin
                next_count[g] = count[g];
                if (e.enable && e.err[g] && count[g] != 16'hFFFF) begin
                    next_count[g] = count[g] + 16'h0001;
                end
            end
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    count[g] <= 16'h0000;
                end else begin
                    count[g] <= next_count[g];
                end
            end
            assign e.flag[g] = (count[g] >= e.limit);
            sat_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
                count[g] == 16'hFFFF |=> count[g] == 16'hFFFF) else $error("counter wrapped");
            no_count_off_a: assert property (@(posedge ref_clk) disable iff (rst)
                !e.enable |=> count[g] == $past(count[g])) else $error("counted while disabled");
        end
    endgenerate
endmodule

// *** hub_global_cfg.sv ***
// Purpose: Global configuration and status register group of a dual-link deserializer hub
// Assumes: Register port is a byte-wide strobe interface shared by two-wire bus and back channel
// Notes: Output pins are registered
`include "hub_cfg_map.svh"
module hub_global_cfg #(
    parameter int PORTS = 2,
    // Revision and mask codes are arbitrary
    parameter logic [3:0] SILICON_REV = 4'h5,
    parameter logic [3:0] MASK_REV = 4'h9,
    parameter logic [15:0] MEAS_WINDOW = `MEAS_WINDOW_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic loc_wr,
    input wire logic loc_rd,
    input wire logic [7:0] loc_addr,
    input wire logic [7:0] loc_wdata,
    input wire logic bc_wr,
    input wire logic bc_rd,
    input wire logic [7:0] bc_addr,
    input wire logic [7:0] bc_wdata,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire logic reload_defaults_cmd,
    input wire logic init_word_valid,
    input wire logic init_word_ok,
    input wire logic ext_refclk_in,
    input wire logic [PORTS-1:0] rx_lock,
    input wire logic [PORTS-1:0] port_assigned,
    input wire logic [PORTS-1:0] parity_err,
    input wire logic pass_in,
    input wire logic remote_bus_req,
    output logic remote_bus_grant,
    output logic remote_bus_nack,
    output hub_cfg_pkg::out_mode_t output_port_mode,
    output logic lock_pin,
    output logic pass_pin,
    output logic [PORTS-1:0] rx_port_status_one,
    output logic parity_checker_on,
    output logic ref_clock_present
);
    import hub_cfg_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Register access, local bus has priority over back channel
    logic wr, rd;
    logic [7:0] addr, wdata;
    logic [7:0] general_configuration, parity_threshold_high, parity_threshold_low;
    logic [7:0] next_general_configuration, next_parity_threshold_high, next_parity_threshold_low;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic refclk_ok, init_done, cksum_ok;
    logic [7:0] device_status, silicon_revision;
    always_comb begin
        wr = loc_wr | (bc_wr & ~loc_wr & ~loc_rd);
        rd = loc_rd | (bc_rd & ~loc_wr & ~loc_rd);
        addr = (loc_wr | loc_rd) ? loc_addr : bc_addr;
        wdata = (loc_wr | loc_rd) ? loc_wdata : bc_wdata;
    end
    assign silicon_revision = {SILICON_REV, MASK_REV};
    assign device_status = {cksum_ok, init_done, 1'b0, refclk_ok, pass_pin, lock_pin, `ST_RESERVED_LOW};
    always_comb begin
        next_general_configuration = general_configuration;
        next_parity_threshold_high = parity_threshold_high;
        next_parity_threshold_low = parity_threshold_low;
        if (reload_defaults_cmd) begin
            next_general_configuration = `RST_GENERAL_CONFIGURATION;
            next_parity_threshold_high = `RST_PARITY_THRESHOLD_HIGH;
            next_parity_threshold_low = `RST_PARITY_THRESHOLD_LOW;
        end else if (wr) begin
            case (addr)
                `OFS_GENERAL_CONFIGURATION: next_general_configuration = wdata & `GC_WRITE_MASK;
                `OFS_PARITY_THRESHOLD_HIGH: next_parity_threshold_high = wdata;
                `OFS_PARITY_THRESHOLD_LOW: next_parity_threshold_low = wdata;
                default: ;
            endcase
        end
        next_rvalid = rd;
        case (addr)
            `OFS_GENERAL_CONFIGURATION: next_rdata = general_configuration;
            `OFS_SILICON_REVISION: next_rdata = silicon_revision;
            `OFS_DEVICE_STATUS: next_rdata = device_status;
            `OFS_PARITY_THRESHOLD_HIGH: next_rdata = parity_threshold_high;
            `OFS_PARITY_THRESHOLD_LOW: next_rdata = parity_threshold_low;
            default: next_rdata = 8'h00;
        endcase
        if (!rd) next_rdata = rdata;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            general_configuration <= `RST_GENERAL_CONFIGURATION;
            parity_threshold_high <= `RST_PARITY_THRESHOLD_HIGH;
            parity_threshold_low <= `RST_PARITY_THRESHOLD_LOW;
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            general_configuration <= next_general_configuration;
            parity_threshold_high <= next_parity_threshold_high;
            parity_threshold_low <= next_parity_threshold_low;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Initialization sequencer; reload restarts it
    init_state_t init_state, next_init_state;
    logic [3:0] init_cnt, next_init_cnt;
    logic sum_bad, next_sum_bad, next_init_done, next_cksum_ok;
    always_comb begin
        next_init_state = init_state;
        next_init_cnt = init_cnt;
        next_sum_bad = sum_bad;
        next_init_done = init_done;
        next_cksum_ok = cksum_ok;
        case (init_state)
            INIT_IDLE: begin
                next_init_state = INIT_LOAD;
                next_init_cnt = 4'h0;
                next_sum_bad = 1'b0;
            end
            INIT_LOAD: begin
                if (init_word_valid) begin
                    next_init_cnt = init_cnt + 4'h1;
                    if (init_cnt == `INIT_WORDS - 4'h1) next_init_state = INIT_CHECK;
                end
            end
            INIT_CHECK: begin
                next_cksum_ok = ~sum_bad;
                next_init_done = 1'b1;
                next_init_state = INIT_DONE;
            end
            INIT_DONE: ;
            default: next_init_state = INIT_IDLE;
        endcase
        if (init_state == INIT_LOAD && init_word_valid && !init_word_ok) next_sum_bad = 1'b1;
        if (reload_defaults_cmd) begin
            next_init_state = INIT_IDLE;
            next_init_done = 1'b0;
            next_cksum_ok = 1'b0;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            init_state <= INIT_IDLE;
            init_cnt <= 4'h0;
            sum_bad <= 1'b0;
            init_done <= 1'b0;
            cksum_ok <= 1'b0;
        end else begin
            init_state <= next_init_state;
            init_cnt <= next_init_cnt;
            sum_bad <= next_sum_bad;
            init_done <= next_init_done;
            cksum_ok <= next_cksum_ok;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Reference clock frequency measurement, edges counted per window
    localparam logic [15:0] EDGE_MIN = 16'((`REFCLK_MIN_MHZ * MEAS_WINDOW) / `CLK_MHZ);
    localparam logic [15:0] EDGE_MAX = 16'((`REFCLK_MAX_MHZ * MEAS_WINDOW) / `CLK_MHZ);
    logic window_tick;
    logic [15:0] edge_cnt, next_edge_cnt;
    logic refclk_q, next_refclk_ok, next_ref_clock_present;
    rate_divider #(.WIDTH(16)) u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .period(MEAS_WINDOW),
        .tick(window_tick)
    );
    always_comb begin
        next_edge_cnt = edge_cnt;
        next_refclk_ok = refclk_ok;
        if (ext_refclk_in && !refclk_q && edge_cnt != 16'hFFFF) next_edge_cnt = edge_cnt + 16'h0001;
        if (window_tick) begin
            next_refclk_ok = (edge_cnt >= EDGE_MIN) && (edge_cnt <= EDGE_MAX);
            next_edge_cnt = 16'h0000;
        end
        next_ref_clock_present = general_configuration[`GC_REFCLK_OVERRIDE] | next_refclk_ok;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            edge_cnt <= 16'h0000;
            refclk_q <= 1'b0;
            refclk_ok <= 1'b0;
            ref_clock_present <= 1'b0;
        end else begin
            edge_cnt <= next_edge_cnt;
            refclk_q <= ext_refclk_in;
            refclk_ok <= next_refclk_ok;
            ref_clock_present <= next_ref_clock_present;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Parity counters
    hub_err_if #(.PORTS(PORTS)) err_bus ();
    assign err_bus.err = parity_err;
    assign err_bus.enable = general_configuration[`GC_PARITY_ENABLE];
    assign err_bus.limit = {parity_threshold_high, parity_threshold_low};
    parity_counters #(.PORTS(PORTS)) u_cnt (
        .ref_clk(ref_clk),
        .rst(rst),
        .e(err_bus.cnt)
    );
    ////////////////////////////////////////////////////////////////////////
    // Output pins, lock, pass, proxy gating
    out_mode_t next_mode;
    logic any_lock, next_grant, next_nack;
    always_comb begin
        any_lock = |(rx_lock & port_assigned);
        if (general_configuration[`GC_SLEEP_SELECT] && !general_configuration[`GC_OUTPUT_ENABLE]) begin
            next_mode = OUT_HIZ;
        end else if (!general_configuration[`GC_SLEEP_SELECT] && !(|rx_lock)) begin
            next_mode = OUT_HS0;
        end else if (!any_lock) begin
            next_mode = general_configuration[`GC_NOLOCK_POLICY] ? OUT_LP11 : OUT_HIZ;
        end else begin
            next_mode = OUT_NORMAL;
        end
        next_grant = remote_bus_req & general_configuration[`GC_PROXY_MASTER];
        next_nack = remote_bus_req & ~general_configuration[`GC_PROXY_MASTER];
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            output_port_mode <= OUT_HIZ;
            lock_pin <= 1'b0;
            pass_pin <= 1'b0;
            rx_port_status_one <= '0;
            parity_checker_on <= 1'b1;
            remote_bus_grant <= 1'b0;
            remote_bus_nack <= 1'b0;
        end else begin
            output_port_mode <= next_mode;
            lock_pin <= |rx_lock;
            pass_pin <= pass_in;
            rx_port_status_one <= err_bus.flag;
            parity_checker_on <= general_configuration[`GC_PARITY_ENABLE];
            remote_bus_grant <= next_grant;
            remote_bus_nack <= next_nack;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    proxy_block_a: assert property (@(posedge ref_clk) disable iff (rst)
        remote_bus_req && !general_configuration[`GC_PROXY_MASTER] |=> !remote_bus_grant) else $error("proxy granted");
    grant_on_a: assert property (@(posedge ref_clk) disable iff (rst)
        remote_bus_req && general_configuration[`GC_PROXY_MASTER] |=> remote_bus_grant) else $error("proxy refused");
    hiz_policy_a: assert property (@(posedge ref_clk) disable iff (rst)
        general_configuration[`GC_SLEEP_SELECT] && general_configuration[`GC_OUTPUT_ENABLE] && !any_lock
        && !general_configuration[`GC_NOLOCK_POLICY] |=> output_port_mode == OUT_HIZ) else $error("no hiz");
    lp11_policy_a: assert property (@(posedge ref_clk) disable iff (rst)
        general_configuration[`GC_SLEEP_SELECT] && general_configuration[`GC_OUTPUT_ENABLE] && !any_lock
        && general_configuration[`GC_NOLOCK_POLICY] |=> output_port_mode == OUT_LP11) else $error("no lp11");
    sleep_hiz_a: assert property (@(posedge ref_clk) disable iff (rst)
        general_configuration[`GC_SLEEP_SELECT] && !general_configuration[`GC_OUTPUT_ENABLE]
        |=> output_port_mode == OUT_HIZ) else $error("no hiz");
    hs_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        !general_configuration[`GC_SLEEP_SELECT] && !(|rx_lock) |=> output_port_mode == OUT_HS0) else $error("no hs0");
    force_ref_a: assert property (@(posedge ref_clk) disable iff (rst)
        general_configuration[`GC_REFCLK_OVERRIDE] |=> ref_clock_present) else $error("override ignored");
    rev_field_a: assert property (@(posedge ref_clk) disable iff (rst)
        rd && addr == `OFS_SILICON_REVISION |=> rdata == {SILICON_REV, MASK_REV}) else $error("bad rev");
    cksum_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
        init_state == INIT_CHECK && !reload_defaults_cmd |=> cksum_ok == !$past(sum_bad))
        else $error("bad checksum bit");
    done_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
        init_state == INIT_CHECK && !reload_defaults_cmd |=> init_done) else $error("init done missing");
    refclk_range_a: assert property (@(posedge ref_clk) disable iff (rst)
        window_tick && (edge_cnt < EDGE_MIN || edge_cnt > EDGE_MAX) |=> !refclk_ok) else $error("refclk out of range");
    lock_mirror_a: assert property (@(posedge ref_clk) disable iff (rst)
        rd && addr == `OFS_DEVICE_STATUS |=> rdata[`ST_LOCK] == $past(lock_pin) && rdata[`ST_PASS] == $past(pass_pin))
        else $error("pin mismatch");
    thold_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr && !reload_defaults_cmd && addr == `OFS_PARITY_THRESHOLD_HIGH |=> parity_threshold_high == $past(wdata))
        else $error("thold write lost");
    thold_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr && !reload_defaults_cmd && addr == `OFS_PARITY_THRESHOLD_LOW |=> parity_threshold_low == $past(wdata))
        else $error("low byte write lost");
    read_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
        rvalid == $past(rd)) else $error("read answer misplaced");
    reload_regs_a: assert property (@(posedge ref_clk) disable iff (rst)
        reload_defaults_cmd |=> general_configuration == `RST_GENERAL_CONFIGURATION
        && parity_threshold_high == `RST_PARITY_THRESHOLD_HIGH && parity_threshold_low == `RST_PARITY_THRESHOLD_LOW)
        else $error("reload missed");
endmodule

// *** rate_divider.sv ***
// Purpose: One-cycle tick every period cycles
// Assumes: period at least 1
// Notes: Used for the measurement window
module rate_divider #(parameter int WIDTH = 16) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] period,
    output logic tick
);
    logic [WIDTH-1:0] cnt, next_cnt;
    logic next_tick;
    always_comb begin
        next_tick = (cnt == period - WIDTH'(1));
        next_cnt = next_tick ? '0 : cnt + WIDTH'(1);
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// *** link_env_model.sv ***
// Purpose: Far-side model feeding config load words and a reference clock
// Assumes: Runs off ref_clk; words start a while after reset release or reload
// Notes: Reference clock stands still while its half period is zero
module link_env_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reload_defaults_cmd,
    input wire logic cfg_good,
    input wire logic [7:0] refclk_half,
    output logic init_word_valid,
    output logic init_word_ok,
    output logic ext_refclk_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rc_cnt;
    initial begin
        init_word_valid = 1'b0;
        init_word_ok = 1'b0;
        ext_refclk_in = 1'b0;
        rc_cnt = 8'h00;
    end
    ////////////////////////////////////////////////////////////////
    // Config load after reset release or reload command
    initial forever begin
        @(negedge rst or posedge reload_defaults_cmd);
        repeat (10) @(negedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            init_word_valid = 1'b1;
            init_word_ok = cfg_good;
            @(negedge ref_clk);
        end
        init_word_valid = 1'b0;
        // Released line flips so a stale level is never mistaken for data
        init_word_ok = ~init_word_ok;
    end
    ////////////////////////////////////////////////////////////////
    // Reference clock at ref_clk rate / (2 * refclk_half)
    always @(negedge ref_clk) begin
        if (refclk_half == 8'h00) begin
            rc_cnt <= 8'h00;
            ext_refclk_in <= 1'b0;
        end else if (rc_cnt >= refclk_half - 8'h01) begin
            rc_cnt <= 8'h00;
            ext_refclk_in <= ~ext_refclk_in;
        end else begin
            rc_cnt <= rc_cnt + 8'h01;
        end
    end
endmodule

// *** hub_global_cfg_tb_top.sv ***
// Purpose: Self-checking bench for the hub configuration and status group
// Assumes: Inputs change at the falling edge; measurement window shortened to 250
// Notes: Register access through the local strobe port and the back channel
`include "hub_cfg_map.svh"
module hub_global_cfg_tb_top;
    import hub_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, loc_wr, loc_rd, bc_wr, bc_rd, reload_defaults_cmd, pass_in, remote_bus_req;
    logic [7:0] loc_addr, loc_wdata, bc_addr, bc_wdata, rdata, q, refclk_half;
    logic rvalid, init_word_valid, init_word_ok, ext_refclk_in, cfg_good;
    logic remote_bus_grant, remote_bus_nack, lock_pin, pass_pin, parity_checker_on, ref_clock_present;
    logic [1:0] rx_lock, port_assigned, parity_err, rx_port_status_one;
    out_mode_t output_port_mode;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] m_cfg [5] = '{8'h1E, 8'h0E, 8'h0E, 8'h1A, 8'h16};
    logic [1:0] m_asg [5] = '{2'h3, 2'h1, 2'h3, 2'h3, 2'h3};
    logic [1:0] m_lck [5] = '{2'h0, 2'h2, 2'h3, 2'h0, 2'h3};
    out_mode_t m_exp [5] = '{OUT_LP11, OUT_HIZ, OUT_NORMAL, OUT_HS0, OUT_HIZ};

    // Revision and mask values are arbitrary
    hub_global_cfg #(.PORTS(2), .SILICON_REV(4'h6), .MASK_REV(4'hB), .MEAS_WINDOW(16'h00FA)) hub_global_cfg_inst (
        .ref_clk(ref_clk), .rst(rst), .loc_wr(loc_wr), .loc_rd(loc_rd), .loc_addr(loc_addr),
        .loc_wdata(loc_wdata), .bc_wr(bc_wr), .bc_rd(bc_rd), .bc_addr(bc_addr), .bc_wdata(bc_wdata),
        .rdata(rdata), .rvalid(rvalid), .reload_defaults_cmd(reload_defaults_cmd),
        .init_word_valid(init_word_valid), .init_word_ok(init_word_ok), .ext_refclk_in(ext_refclk_in),
        .rx_lock(rx_lock), .port_assigned(port_assigned), .parity_err(parity_err), .pass_in(pass_in),
        .remote_bus_req(remote_bus_req), .remote_bus_grant(remote_bus_grant), .remote_bus_nack(remote_bus_nack),
        .output_port_mode(output_port_mode), .lock_pin(lock_pin), .pass_pin(pass_pin),
        .rx_port_status_one(rx_port_status_one), .parity_checker_on(parity_checker_on),
        .ref_clock_present(ref_clock_present));
    link_env_model link_env_model_inst (
        .ref_clk(ref_clk), .rst(rst), .reload_defaults_cmd(reload_defaults_cmd), .cfg_good(cfg_good),
        .refclk_half(refclk_half), .init_word_valid(init_word_valid), .init_word_ok(init_word_ok),
        .ext_refclk_in(ext_refclk_in));
    ////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Ceiling well above the three measurement phases plus register traffic
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic acc(input logic bc, input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        if (bc) begin
            bc_wr = wr; bc_rd = !wr; bc_addr = a; bc_wdata = d;
        end else begin
            loc_wr = wr; loc_rd = !wr; loc_addr = a; loc_wdata = d;
        end
        @(negedge ref_clk);
        {loc_wr, loc_rd, bc_wr, bc_rd} = 4'h0;
        // Released address and data flip so stale values never look valid
        {loc_addr, loc_wdata, bc_addr, bc_wdata} = ~{loc_addr, loc_wdata, bc_addr, bc_wdata};
        q = rdata;
        if (!wr) check("rvalid", {7'h00, rvalid}, 8'h01);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b0, 1'b1, a, d);
    endtask
    task automatic rd(input string name, input logic bc, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        acc(bc, 1'b0, a, 8'h00);
        check(name, q & m, e);
    endtask
    task automatic err_pulses(input int p, input int n);
        repeat (n) begin
            @(negedge ref_clk);
            parity_err[p] = 1'b1;
            @(negedge ref_clk);
            parity_err[p] = 1'b0;
        end
        tick(3);
    endtask
    task automatic do_reset();
        rst = 1'b1;
        tick(12);
        rst = 1'b0;
        tick(40);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {loc_wr, loc_rd, bc_wr, bc_rd, reload_defaults_cmd, pass_in, remote_bus_req} = 7'h00;
        {loc_addr, loc_wdata, bc_addr, bc_wdata, refclk_half} = 40'h0;
        {rx_lock, parity_err} = 4'h0;
        port_assigned = 2'h3;
        cfg_good = 1'b1;
        do_reset();
        rd("gen_cfg", 0, `OFS_GENERAL_CONFIGURATION, 8'hFF, 8'h1E);
        rd("thr_hi", 0, `OFS_PARITY_THRESHOLD_HIGH, 8'hFF, 8'h01);
        rd("thr_lo", 0, `OFS_PARITY_THRESHOLD_LOW, 8'hFF, 8'h00);
        wr(`OFS_SILICON_REVISION, 8'h00);
        rd("revision", 0, `OFS_SILICON_REVISION, 8'hFF, 8'h6B);
        wr(8'h10, 8'hA5);
        rd("unmapped", 0, 8'h10, 8'hFF, 8'h00);
        rd("status", 0, `OFS_DEVICE_STATUS, 8'hFF, 8'hC3);
        wr(`OFS_GENERAL_CONFIGURATION, 8'hFF);
        rd("gen_cfg_rsv", 0, `OFS_GENERAL_CONFIGURATION, 8'hFF, 8'h3F);
        // Proxy mastering gate
        remote_bus_req = 1'b1;
        wr(`OFS_GENERAL_CONFIGURATION, 8'h1E);
        tick(3);
        check("grant_off", {6'h00, remote_bus_grant, remote_bus_nack}, 8'h01);
        wr(`OFS_GENERAL_CONFIGURATION, 8'h3E);
        tick(3);
        check("grant_on", {6'h00, remote_bus_grant, remote_bus_nack}, 8'h02);
        remote_bus_req = 1'b0;
        // Output port mode table
        for (int i = 0; i < 5; i++) begin
            port_assigned = m_asg[i];
            rx_lock = m_lck[i];
            wr(`OFS_GENERAL_CONFIGURATION, m_cfg[i]);
            tick(3);
            check("out_mode", {6'h00, output_port_mode}, {6'h00, m_exp[i]});
        end
        // Pins mirrored in status
        rx_lock = 2'h1;
        pass_in = 1'b1;
        tick(3);
        check("pins", {6'h00, lock_pin, pass_pin}, 8'h03);
        rd("status_pins", 1, `OFS_DEVICE_STATUS, 8'hFF, 8'hCF);
        {rx_lock, pass_in} = 3'h0;
        tick(3);
        rd("status_idle", 0, `OFS_DEVICE_STATUS, 8'h0C, 8'h00);
        // Reference clock measurement: 31.25, 125, 4.2 MHz
        wr(`OFS_GENERAL_CONFIGURATION, 8'h1E);
        refclk_half = 8'h04;
        tick(800);
        rd("refclk_mid", 0, `OFS_DEVICE_STATUS, 8'h10, 8'h10);
        check("present", {7'h00, ref_clock_present}, 8'h01);
        refclk_half = 8'h01;
        tick(800);
        rd("refclk_fast", 0, `OFS_DEVICE_STATUS, 8'h10, 8'h00);
        refclk_half = 8'h1E;
        tick(800);
        rd("refclk_slow", 0, `OFS_DEVICE_STATUS, 8'h10, 8'h00);
        check("absent", {7'h00, ref_clock_present}, 8'h00);
        refclk_half = 8'h00;
        wr(`OFS_GENERAL_CONFIGURATION, 8'h1F);
        tick(3);
        check("forced", {7'h00, ref_clock_present}, 8'h01);
        // Parity threshold of 3, enable gating
        wr(`OFS_GENERAL_CONFIGURATION, 8'h1E);
        wr(`OFS_PARITY_THRESHOLD_HIGH, 8'h00);
        wr(`OFS_PARITY_THRESHOLD_LOW, 8'h03);
        err_pulses(0, 2);
        check("below_thr", {6'h00, rx_port_status_one}, 8'h00);
        err_pulses(0, 1);
        check("at_thr", {6'h00, rx_port_status_one}, 8'h01);
        wr(`OFS_GENERAL_CONFIGURATION, 8'h1C);
        tick(3);
        check("chk_off", {7'h00, parity_checker_on}, 8'h00);
        err_pulses(1, 3);
        check("disabled", {6'h00, rx_port_status_one}, 8'h01);
        wr(`OFS_GENERAL_CONFIGURATION, 8'h1E);
        err_pulses(1, 3);
        check("enabled", {6'h00, rx_port_status_one}, 8'h03);
        do_reset();
        check("flags_clear", {6'h00, rx_port_status_one}, 8'h00);
        // Back channel access, local wins on collision
        acc(1'b1, 1'b1, `OFS_PARITY_THRESHOLD_LOW, 8'h5A);
        rd("bc_write", 0, `OFS_PARITY_THRESHOLD_LOW, 8'hFF, 8'h5A);
        @(negedge ref_clk);
        {loc_wr, bc_wr, loc_addr, bc_addr} = {2'h3, `OFS_PARITY_THRESHOLD_LOW, `OFS_PARITY_THRESHOLD_LOW};
        {loc_wdata, bc_wdata} = 16'h1122;
        @(negedge ref_clk);
        {loc_wr, bc_wr} = 2'h0;
        rd("collide", 1, `OFS_PARITY_THRESHOLD_LOW, 8'hFF, 8'h11);
        // Reload with bad then good checksum
        for (int g = 0; g < 2; g++) begin
            cfg_good = g[0];
            wr(`OFS_PARITY_THRESHOLD_HIGH, 8'h77);
            @(negedge ref_clk);
            reload_defaults_cmd = 1'b1;
            @(negedge ref_clk);
            reload_defaults_cmd = 1'b0;
            tick(2);
            rd("reload_busy", 0, `OFS_DEVICE_STATUS, 8'h40, 8'h00);
            rd("reload_thr", 0, `OFS_PARITY_THRESHOLD_HIGH, 8'hFF, 8'h01);
            tick(40);
            rd("reload_done", 0, `OFS_DEVICE_STATUS, 8'hC0, {g[0], 7'h40});
        end
        conclude();
    end
endmodule
